// ===== hdl/rar_pkg.sv
// Purpose : Constants for the remote target alias remap block
// Assumes : Byte-wide register port, 7-bit target addresses
// Notes   : Shared by the design and by the bench

package rar_pkg;

   // ****************************************************
   // Table sizes
   // ****************************************************
   localparam int unsigned NUM_PORTS = 2;
   localparam int unsigned NUM_TGT   = 7;
   localparam int unsigned NUM_ALIAS = 5;
   localparam int unsigned ADDR_W    = 7;
   localparam int unsigned IDX_W     = 3;

   // ****************************************************
   // Register offsets
   // ****************************************************
   localparam logic [7:0] REMOTE_TARGET_ADDR_1_OFS = 8'h70;
   localparam logic [7:0] REMOTE_TARGET_ADDR_2_OFS = 8'h71;
   localparam logic [7:0] REMOTE_TARGET_ADDR_3_OFS = 8'h72;
   localparam logic [7:0] REMOTE_TARGET_ADDR_4_OFS = 8'h73;
   localparam logic [7:0] REMOTE_TARGET_ADDR_5_OFS = 8'h74;
   localparam logic [7:0] REMOTE_TARGET_ADDR_6_OFS = 8'h75;
   localparam logic [7:0] REMOTE_TARGET_ADDR_7_OFS = 8'h76;
   localparam logic [7:0] ALIAS_MATCH_ADDR_1_OFS   = 8'h77;
   localparam logic [7:0] ALIAS_MATCH_ADDR_2_OFS   = 8'h78;
   localparam logic [7:0] ALIAS_MATCH_ADDR_3_OFS   = 8'h79;
   localparam logic [7:0] ALIAS_MATCH_ADDR_4_OFS   = 8'h7a;
   localparam logic [7:0] ALIAS_MATCH_ADDR_5_OFS   = 8'h7b;
   localparam logic [7:0] PORT_SELECT_OFS          = 8'h7c;

   // ****************************************************
   // Field layout and reset values
   // ****************************************************
   localparam int unsigned ADDR_FIELD_MSB  = 7;
   localparam int unsigned ADDR_FIELD_LSB  = 1;
   localparam int unsigned PORT_SELECT_BIT = 0;
   localparam logic [6:0]  ADDR_RESET      = 7'h00;
   localparam logic        PORT_SEL_RESET  = 1'b0;
   localparam logic [7:0]  READ_IDLE       = 8'h00;

endpackage

// ===== hdl/rar_top.sv
// Purpose : Alias to remote target address remap table for two link ports
// Assumes : Register port strobes and lookups synchronous to i_core_clk
// Notes   : Lookup answers one cycle after the request, never stalls
//
// Operation
// - Hold 7-bit target address, reset zero
// - Alias match rewrites address, forwards transaction
// - Zero target blocks forwarding for entry
// - Hold 7-bit alias, match and remap
// - Zero alias never matches any transaction
// - Port select steers register accesses to port
// - Target entry 1 sits below entry 2
// - Alias entries 4 and 5, same layout

`timescale 1ns/10ps

module rar_top
   import rar_pkg::*;
(
   input  wire logic               i_core_clk,
   input  wire logic               i_reset_n,
   input  wire logic [7:0]         i_reg_addr,
   input  wire logic [7:0]         i_reg_wdata,
   input  wire logic               i_reg_wr,
   input  wire logic               i_reg_rd,
   output logic      [7:0]         o_reg_rdata,
   output logic                    o_port_select,
   input  wire logic               i_txn_valid,
   input  wire logic               i_txn_port,
   input  wire logic [ADDR_W-1:0]  i_txn_addr,
   output logic                    o_fwd_valid,
   output logic                    o_fwd_port,
   output logic      [ADDR_W-1:0]  o_fwd_addr,
   output logic      [IDX_W-1:0]   o_fwd_entry,
   output logic                    o_blocked,
   output logic                    o_miss
);

   // ****************************************************
   // Address decode
   // ****************************************************
   function automatic logic is_tgt(input logic [7:0] a);
      return (a >= REMOTE_TARGET_ADDR_1_OFS) && (a <= REMOTE_TARGET_ADDR_7_OFS);
   endfunction

   function automatic logic is_alias(input logic [7:0] a);
      return (a >= ALIAS_MATCH_ADDR_1_OFS) && (a <= ALIAS_MATCH_ADDR_5_OFS);
   endfunction

   function automatic logic [IDX_W-1:0] tgt_idx(input logic [7:0] a);
      logic [7:0] d;
      d = a - REMOTE_TARGET_ADDR_1_OFS + 8'h01;
      return d[IDX_W-1:0];
   endfunction

   function automatic logic [IDX_W-1:0] alias_idx(input logic [7:0] a);
      logic [7:0] d;
      d = a - ALIAS_MATCH_ADDR_1_OFS + 8'h01;
      return d[IDX_W-1:0];
   endfunction

   // ****************************************************
   // Table storage
   // ****************************************************
   logic [ADDR_W-1:0] tgt_reg   [NUM_PORTS][1:NUM_TGT];
   logic [ADDR_W-1:0] alias_reg [NUM_PORTS][1:NUM_ALIAS];
   logic              port_sel_reg;

   logic              wr_tgt;
   logic              wr_alias;
   logic [IDX_W-1:0]  wr_tgt_idx;
   logic [IDX_W-1:0]  wr_alias_idx;
   logic [ADDR_W-1:0] wr_field;

   assign wr_tgt       = i_reg_wr && is_tgt(i_reg_addr);
   assign wr_alias     = i_reg_wr && is_alias(i_reg_addr);
   assign wr_tgt_idx   = tgt_idx(i_reg_addr);
   assign wr_alias_idx = alias_idx(i_reg_addr);
   // Bit 0 is dropped here so it never reaches storage
   assign wr_field     = i_reg_wdata[ADDR_FIELD_MSB:ADDR_FIELD_LSB];

   // Only the selected port's copy takes the write
   for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
      for (genvar k = 1; k <= NUM_TGT; k++) begin : g_tgt
         always_ff @(posedge i_core_clk or negedge i_reset_n) begin
            if (!i_reset_n) begin
               tgt_reg[p][k] <= ADDR_RESET;
            end else if (wr_tgt && wr_tgt_idx == IDX_W'(k) && port_sel_reg == 1'(p)) begin
               tgt_reg[p][k] <= wr_field;
            end
         end
      end
      for (genvar k = 1; k <= NUM_ALIAS; k++) begin : g_alias
         always_ff @(posedge i_core_clk or negedge i_reset_n) begin
            if (!i_reset_n) begin
               alias_reg[p][k] <= ADDR_RESET;
            end else if (wr_alias && wr_alias_idx == IDX_W'(k) && port_sel_reg == 1'(p)) begin
               alias_reg[p][k] <= wr_field;
            end
         end
      end
   end

   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         port_sel_reg <= PORT_SEL_RESET;
      end else if (i_reg_wr && i_reg_addr == PORT_SELECT_OFS) begin
         port_sel_reg <= i_reg_wdata[PORT_SELECT_BIT];
      end
   end

   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_port_select <= PORT_SEL_RESET;
      end else begin
         o_port_select <= (i_reg_wr && i_reg_addr == PORT_SELECT_OFS) ?
                          i_reg_wdata[PORT_SELECT_BIT] : port_sel_reg;
      end
   end

   // ****************************************************
   // Register read
   // ****************************************************
   logic [7:0] rd_next;

   always_comb begin
      rd_next = READ_IDLE;
      if (is_tgt(i_reg_addr)) begin
         rd_next = {tgt_reg[port_sel_reg][tgt_idx(i_reg_addr)], 1'b0};
      end else if (is_alias(i_reg_addr)) begin
         rd_next = {alias_reg[port_sel_reg][alias_idx(i_reg_addr)], 1'b0};
      end else if (i_reg_addr == PORT_SELECT_OFS) begin
         rd_next = {7'h00, port_sel_reg};
      end
   end

   // Data stand only in the cycle after the strobe
   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_reg_rdata <= READ_IDLE;
      end else begin
         o_reg_rdata <= i_reg_rd ? rd_next : READ_IDLE;
      end
   end

   // ****************************************************
   // Alias lookup
   // ****************************************************
   logic              hit;
   logic [IDX_W-1:0]  hit_idx;
   logic [ADDR_W-1:0] hit_tgt;

   // Lowest entry wins when software programs a duplicate alias
   always_comb begin
      hit     = 1'b0;
      hit_idx = IDX_W'(1);
      for (int k = NUM_ALIAS; k >= 1; k--) begin
         if (alias_reg[i_txn_port][k] != ADDR_RESET &&
             alias_reg[i_txn_port][k] == i_txn_addr) begin
            hit     = 1'b1;
            hit_idx = IDX_W'(k);
         end
      end
      hit_tgt = hit ? tgt_reg[i_txn_port][hit_idx] : ADDR_RESET;
   end

   // ****************************************************
   // Forward decision
   // ****************************************************
   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_fwd_valid <= 1'b0;
         o_blocked   <= 1'b0;
         o_miss      <= 1'b0;
      end else begin
         o_fwd_valid <= i_txn_valid && hit && hit_tgt != ADDR_RESET;
         o_blocked   <= i_txn_valid && hit && hit_tgt == ADDR_RESET;
         o_miss      <= i_txn_valid && !hit;
      end
   end

   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_fwd_port  <= 1'b0;
         o_fwd_addr  <= ADDR_RESET;
         o_fwd_entry <= '0;
      end else if (i_txn_valid && hit && hit_tgt != ADDR_RESET) begin
         o_fwd_port  <= i_txn_port;
         o_fwd_addr  <= hit_tgt;
         o_fwd_entry <= hit_idx;
      end
   end

   // ****************************************************
   // Assertions
   // ****************************************************
   sequence s_tgt_write;
      i_reg_wr && is_tgt(i_reg_addr);
   endsequence

   sequence s_alias_write;
      i_reg_wr && is_alias(i_reg_addr);
   endsequence

   sequence s_hit_live;
      i_txn_valid && hit && hit_tgt != ADDR_RESET;
   endsequence

   sequence s_hit_dead;
      i_txn_valid && hit && hit_tgt == ADDR_RESET;
   endsequence

   sequence s_tgt1_write;
      i_reg_wr && i_reg_addr == REMOTE_TARGET_ADDR_1_OFS;
   endsequence

   // Write then read of entry one with no gap between strobes
   sequence s_tgt1_readback;
      s_tgt1_write ##1 (i_reg_rd && i_reg_addr == REMOTE_TARGET_ADDR_1_OFS);
   endsequence

   sequence s_port_write;
      i_reg_wr && i_reg_addr == PORT_SELECT_OFS;
   endsequence

   sequence s_unmapped_read;
      i_reg_rd && !is_tgt(i_reg_addr) && !is_alias(i_reg_addr)
      && i_reg_addr != PORT_SELECT_OFS;
   endsequence

   sequence s_entry1_match;
      i_txn_valid && alias_reg[i_txn_port][1] != ADDR_RESET
      && alias_reg[i_txn_port][1] == i_txn_addr;
   endsequence

   tgt_write_store_a: assert property (
      @(posedge i_core_clk) disable iff (!i_reset_n)
      s_tgt_write |=> tgt_reg[$past(port_sel_reg)][$past(wr_tgt_idx)] == $past(wr_field))
      else $error("target entry did not store written field");

   tgt_other_port_a: assert property (
      @(posedge i_core_clk) disable iff (!i_reset_n)
      s_tgt_write |=> tgt_reg[!$past(port_sel_reg)][$past(wr_tgt_idx)]
                      == $past(tgt_reg[!port_sel_reg][wr_tgt_idx]))
      else $error("target write leaked into unselected port");

   tgt_one_entry_a: assert property (
      @(posedge i_core_clk) disable iff (!i_reset_n)
      s_tgt1_write |=> tgt_reg[$past(port_sel_reg)][1]
                       == $past(i_reg_wdata[ADDR_FIELD_MSB:ADDR_FIELD_LSB]))
      else $error("target entry one not at lowest offset");

   alias_write_store_a: assert property (
      @(posedge i_core_clk) disable iff (!i_reset_n)
      s_alias_write |=> alias_reg[$past(port_sel_reg)][$past(wr_alias_idx)] == $past(wr_field))
      else $error("alias entry did not store written field");

   alias_high_entry_a: assert property (
      @(posedge i_core_clk) disable iff (!i_reset_n)
      (i_reg_wr && i_reg_addr == ALIAS_MATCH_ADDR_5_OFS)
      |=> alias_reg[$past(port_sel_reg)][5] == $past(i_reg_wdata[7:1]))
      else $error("alias entry five not stored");

   fwd_remap_a: assert property (
      @(posedge i_core_clk) disable iff (!i_reset_n)
      s_hit_live |=> o_fwd_valid && !o_blocked && o_fwd_addr == $past(hit_tgt)
                     && o_fwd_entry == $past(hit_idx) && o_fwd_port == $past(i_txn_port))
      else $error("matched alias not forwarded with remapped address");

   fwd_blocked_a: assert property (
      @(posedge i_core_clk) disable iff (!i_reset_n)
      s_hit_dead |=> o_blocked && !o_fwd_valid ##1 !o_blocked || $past(i_txn_valid))
      else $error("zero target entry was not blocked");

   zero_alias_a: assert property (
      @(posedge i_core_clk) disable iff (!i_reset_n)
      (i_txn_valid && i_txn_addr == ADDR_RESET) |=> !o_fwd_valid && !o_blocked && o_miss)
      else $error("zero alias matched a transaction");

   reserved_bit_a: assert property (
      @(posedge i_core_clk) disable iff (!i_reset_n)
      i_reg_rd && (is_tgt(i_reg_addr) || is_alias(i_reg_addr))
      |=> o_reg_rdata[0] == 1'b0 && o_reg_rdata[7:1] == $past(rd_next[7:1]))
      else $error("reserved bit read back nonzero");

   tgt_one_readback_a: assert property (
      @(posedge i_core_clk) disable iff (!i_reset_n)
      s_tgt1_readback |=> o_reg_rdata
                          == {$past(i_reg_wdata[ADDR_FIELD_MSB:ADDR_FIELD_LSB], 2), 1'b0})
      else $error("target entry one not read back after write");

   alias_other_port_a: assert property (
      @(posedge i_core_clk) disable iff (!i_reset_n)
      s_alias_write |=> alias_reg[!$past(port_sel_reg)][$past(wr_alias_idx)]
                        == $past(alias_reg[!port_sel_reg][wr_alias_idx]))
      else $error("alias write leaked into unselected port");

   port_write_a: assert property (
      @(posedge i_core_clk) disable iff (!i_reset_n)
      s_port_write |=> port_sel_reg == $past(i_reg_wdata[PORT_SELECT_BIT])
                       && o_port_select == port_sel_reg)
      else $error("port select write not taken");

   port_track_a: assert property (
      @(posedge i_core_clk) disable iff (!i_reset_n)
      o_port_select == port_sel_reg)
      else $error("port select output differs from register");

   read_idle_a: assert property (
      @(posedge i_core_clk) disable iff (!i_reset_n)
      !i_reg_rd |=> o_reg_rdata == READ_IDLE)
      else $error("read data present without a read strobe");

   unmapped_read_a: assert property (
      @(posedge i_core_clk) disable iff (!i_reset_n)
      s_unmapped_read |=> o_reg_rdata == READ_IDLE)
      else $error("unmapped offset returned nonzero data");

   one_outcome_a: assert property (
      @(posedge i_core_clk) disable iff (!i_reset_n)
      i_txn_valid |=> $onehot({o_fwd_valid, o_blocked, o_miss}))
      else $error("lookup did not give exactly one outcome");

   quiet_idle_a: assert property (
      @(posedge i_core_clk) disable iff (!i_reset_n)
      !i_txn_valid |=> !o_fwd_valid && !o_blocked && !o_miss)
      else $error("lookup outcome without a request");

   fwd_nonzero_a: assert property (
      @(posedge i_core_clk) disable iff (!i_reset_n)
      o_fwd_valid |-> o_fwd_addr != ADDR_RESET)
      else $error("zero target address forwarded");

   fwd_entry_range_a: assert property (
      @(posedge i_core_clk) disable iff (!i_reset_n)
      o_fwd_valid |-> o_fwd_entry >= IDX_W'(1) && o_fwd_entry <= IDX_W'(NUM_ALIAS))
      else $error("forward names an entry outside the alias table");

   fwd_hold_a: assert property (
      @(posedge i_core_clk) disable iff (!i_reset_n)
      !(i_txn_valid && hit && hit_tgt != ADDR_RESET)
      |=> $stable(o_fwd_addr) && $stable(o_fwd_entry) && $stable(o_fwd_port))
      else $error("forward fields moved without a forward");

   entry_one_wins_a: assert property (
      @(posedge i_core_clk) disable iff (!i_reset_n)
      s_entry1_match |=> (o_fwd_valid && o_fwd_entry == IDX_W'(1)
                          && o_fwd_addr == $past(tgt_reg[i_txn_port][1])) || o_blocked)
      else $error("entry one alias not taken first");

endmodule

// ===== tb/rar_far_end.sv
// Purpose : Local controller and remote end around the remap block
// Assumes : Requests launched right after a rising edge
// Notes   : Released request lines are scrambled, not held

`timescale 1ns/10ps

module rar_far_end (
   input  wire logic       i_core_clk,
   input  wire logic       i_fwd_valid,
   output logic            o_txn_valid,
   output logic            o_txn_port,
   output logic [6:0]      o_txn_addr
);
   int fwd_count = 0;

   initial begin
      o_txn_valid = 1'b0;
      o_txn_port  = 1'b0;
      o_txn_addr  = 7'h00;
   end

   // Remote end counts every forwarded transaction
   always @(posedge i_core_clk) begin
      if (i_fwd_valid === 1'b1) fwd_count++;
   end

   // One request; lines inverted after release so stale values never match
   task automatic send(input logic p, input logic [6:0] a);
      o_txn_valid <= 1'b1;
      o_txn_port  <= p;
      o_txn_addr  <= a;
      @(posedge i_core_clk);
      o_txn_valid <= 1'b0;
      o_txn_port  <= ~p;
      o_txn_addr  <= ~a;
      #1;
   endtask
endmodule

// ===== tb/rar_top_tb_top.sv
// Purpose : Self-checking bench for the alias remap table
// Assumes : Reference model kept in arrays, updated on every write
// Notes   : Narrow random values force duplicate and zero entries

`timescale 1ns/10ps

module rar_top_tb_top;
   import rar_pkg::*;
   logic       clk, rst_n, wr, rd, ps, txv, txp, fv, fp, blk, ms, psel_o;
   logic [7:0] ra, wd, rdat;
   logic [6:0] txa, fa;
   logic [2:0] fe;
   logic [6:0] tgt [2][8] = '{default: 7'h00};
   logic [6:0] als [2][6] = '{default: 7'h00};
   int         fail_count, samples_checked, cyc, seed, fwd_exp;

   rar_top i_rar_top (.i_core_clk(clk), .i_reset_n(rst_n), .i_reg_addr(ra), .i_reg_wdata(wd),
      .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdat), .o_port_select(psel_o),
      .i_txn_valid(txv), .i_txn_port(txp), .i_txn_addr(txa), .o_fwd_valid(fv),
      .o_fwd_port(fp), .o_fwd_addr(fa), .o_fwd_entry(fe), .o_blocked(blk), .o_miss(ms));
   rar_far_end i_rar_far_end (.i_core_clk(clk), .i_fwd_valid(fv), .o_txn_valid(txv),
      .o_txn_port(txp), .o_txn_addr(txa));

   // ****************************************************
   // Checking and closing
   // ****************************************************
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic give_verdict;
      if (fail_count == 0 && samples_checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   function automatic logic [7:0] exp_rd(input logic [7:0] a);
      if (a == 8'h7c) return {7'h00, ps};
      if (a >= 8'h70 && a <= 8'h76) return {tgt[ps][a - 8'h6f], 1'b0};
      if (a >= 8'h77 && a <= 8'h7b) return {als[ps][a - 8'h76], 1'b0};
      return 8'h00;
   endfunction

   // ****************************************************
   // Register port and lookup tasks
   // ****************************************************
   task automatic wreg(input logic [7:0] a, input logic [7:0] d);
      wr <= 1'b1;
      ra <= a;
      wd <= d;
      @(posedge clk);
      wr <= 1'b0;
      if (a == 8'h7c) ps = d[0];
      else if (a >= 8'h70 && a <= 8'h76) tgt[ps][a - 8'h6f] = d[7:1];
      else if (a >= 8'h77 && a <= 8'h7b) als[ps][a - 8'h76] = d[7:1];
      @(posedge clk);
   endtask

   task automatic rreg(input logic [7:0] a);
      rd <= 1'b1;
      ra <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk({rdat, 7'h00, psel_o}, {exp_rd(a), 7'h00, ps});
      @(posedge clk);
      #1;
      chk(16'(rdat), 16'h0000);
      @(posedge clk);
   endtask

   task automatic look(input int p, input int a);
      int hit;
      hit = 0;
      for (int n = 5; n >= 1; n--) if (als[p][n] == a && a != 0) hit = n;
      i_rar_far_end.send(p[0], a[6:0]);
      chk(16'({fv, blk, ms}), 16'(hit == 0 ? 3'b001 : (tgt[p][hit] == 0 ? 3'b010 : 3'b100)));
      if (hit != 0 && tgt[p][hit] != 0) begin
         fwd_exp++;
         chk(16'({fp, fe, fa}), 16'({p[0], hit[2:0], tgt[p][hit]}));
      end
      @(posedge clk);
   endtask

   // ****************************************************
   // Clock, timeout and main sequence
   // ****************************************************
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // Whole run is about 700 cycles; ceiling leaves ample margin
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         give_verdict();
      end
   end

   initial begin
      rst_n = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      ra = 8'h00;
      wd = 8'h00;
      ps = 1'b0;
      seed = 1;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      for (int a = 8'h6f; a <= 8'h7d; a++) rreg(a[7:0]);
      for (int r = 0; r < 3; r++) begin
         for (int p = 0; p < 2; p++) begin
            wreg(8'h7c, {7'h7f, p[0]});
            for (int a = 8'h70; a <= 8'h7d; a++)
               wreg(a[7:0], 8'($random(seed)) & (r == 0 ? 8'hff : (r == 1 ? 8'h0f : 8'h07)));
         end
         for (int p = 0; p < 2; p++) begin
            wreg(8'h7c, {7'h00, p[0]});
            for (int a = 8'h70; a <= 8'h7c; a++) rreg(a[7:0]);
            for (int a = 0; a < 8; a++) look(p, a);
            for (int n = 1; n <= 5; n++) look(p, als[p][n]);
            look(p, $random(seed) & 127);
         end
      end
      // Reset again mid-run: table and outputs must clear
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      tgt = '{default: 7'h00};
      als = '{default: 7'h00};
      ps = 1'b0;
      @(posedge clk);
      #1;
      chk(16'({fv, blk, ms, psel_o, fp, fe, fa}), 16'h0000);
      @(posedge clk);
      for (int a = 8'h70; a <= 8'h7c; a++) rreg(a[7:0]);
      // Entry one written then read back with no gap between strobes
      wd <= 8'($random(seed));
      ra <= REMOTE_TARGET_ADDR_1_OFS;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      rd <= 1'b1;
      tgt[ps][1] = wd[7:1];
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk(16'(rdat), 16'(exp_rd(REMOTE_TARGET_ADDR_1_OFS)));
      @(posedge clk);
      repeat (2) @(posedge clk);
      chk(i_rar_far_end.fwd_count[15:0], fwd_exp[15:0]);
      give_verdict();
   end
endmodule
